//--- mcd_core.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module mcd_core import mcd_pkg::*; #(
    parameter int STACK_DEPTH = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    output logic [PC_W-1:0] PROG_ADDR,
    input wire logic [INSTR_W-1:0] PROG_DATA,
    input wire logic WAKE,
    input wire logic [FILE_AW-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic [DATA_W-1:0] ACC,
    output logic CARRY,
    output logic HALF_CARRY,
    output logic ZERO,
    output logic TIMEOUT,
    output logic POWERDOWN,
    output logic IRQ_ENABLE,
    output logic HALTED,
    output logic SPR_WE,
    output logic [SPR_AW-1:0] SPR_ADDR,
    output logic [DATA_W-1:0] SPR_DATA
);
    mcd_core_if cif();

    mcd_alu u_alu (
        .bus(cif.alu)
    );

    mcd_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clk(MCLK),
        .rst(RST),
        .bus(cif.stk)
    );

    mcd_state_t state;
    logic [PC_W-1:0] ex_pc;
    logic [DATA_W-1:0] file_mem [FILE_DEPTH];
    logic wake_meta;
    logic wake_sync;
    mcd_op_t op;
    logic [FILE_AW-1:0] fidx;
    logic to_file;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] fv;
    logic dest_op;
    logic is_return;

    // Word on PROG_DATA is the one fetched from the previous PROG_ADDR
    assign op = (state == ST_RUN) ? mcd_decode(PROG_DATA) : OP_NOP;
    assign fidx = PROG_DATA[6:0];
    assign to_file = PROG_DATA[7];
    assign lit = PROG_DATA[7:0];
    assign fv = file_mem[fidx];
    assign dest_op = (op == OP_ROT_LEFT) || (op == OP_ROT_RIGHT)
                     || (op == OP_FILE_MINUS_ACC) || (op == OP_NIBBLE)
                     || (op == OP_XOR_FILE);
    assign is_return = (op == OP_SUB_EXIT) || (op == OP_INT_EXIT)
                       || (op == OP_TABLE_EXIT);

    always_comb begin
        cif.op = op;
        cif.a = (op == OP_XOR_LIT) ? lit : fv;
        cif.b = ACC;
        cif.cin = CARRY;
        cif.push = (op == OP_CALL);
        cif.pop = is_return;
        cif.din = PC_W'(ex_pc + 1'b1);
    end

    // Wake pin crosses into MCLK; only the second stage is looked at
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= WAKE;
            wake_sync <= wake_meta;
        end
    end

    // Fetch sequencing: a taken change of flow discards one fetched word,
    // which is what makes returns and calls take two cycles
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state <= ST_REFILL;
            PROG_ADDR <= RST_PC;
            ex_pc <= RST_PC;
            HALTED <= 1'b0;
        end else begin
            case (state)
                ST_REFILL: begin
                    ex_pc <= PROG_ADDR;
                    PROG_ADDR <= PC_W'(PROG_ADDR + 1'b1);
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    if (is_return) begin
                        PROG_ADDR <= cif.top;
                        state <= ST_REFILL;
                    end else if (op == OP_CALL) begin
                        PROG_ADDR <= PROG_DATA[9:0];
                        state <= ST_REFILL;
                    end else if (op == OP_STANDBY) begin
                        state <= ST_SLEEP;
                        HALTED <= 1'b1;
                    end else begin
                        ex_pc <= PROG_ADDR;
                        PROG_ADDR <= PC_W'(PROG_ADDR + 1'b1);
                    end
                end
                ST_SLEEP: begin
                    // Halted: no fetch advances until the wake pin rises
                    if (wake_sync) begin
                        state <= ST_REFILL;
                        HALTED <= 1'b0;
                    end
                end
                default: state <= ST_REFILL;
            endcase
        end
    end

    // Accumulator
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ACC <= RST_ACC;
        end else if (op == OP_TABLE_EXIT) begin
            ACC <= lit;
        end else if (op == OP_XOR_LIT) begin
            ACC <= cif.res;
        end else if (dest_op && !to_file) begin
            ACC <= cif.res;
        end
    end

    // Status flags; moves, returns and nibble exchange leave them alone
    always_ff @(posedge MCLK) begin
        if (RST) begin
            CARRY <= 1'b0;
            HALF_CARRY <= 1'b0;
            ZERO <= 1'b0;
        end else begin
            case (op)
                OP_ROT_LEFT, OP_ROT_RIGHT: begin
                    CARRY <= cif.cout;
                end
                OP_FILE_MINUS_ACC: begin
                    CARRY <= cif.cout;
                    HALF_CARRY <= cif.hcarry;
                    ZERO <= cif.zero;
                end
                OP_ZERO_TEST, OP_XOR_LIT, OP_XOR_FILE: begin
                    ZERO <= cif.zero;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            TIMEOUT <= RST_TIMEOUT;
            POWERDOWN <= RST_POWERDOWN;
        end else if (op == OP_STANDBY) begin
            TIMEOUT <= 1'b1;
            POWERDOWN <= 1'b0;
        end
    end

    // Only interrupt exit touches the enable; entry lives elsewhere
    always_ff @(posedge MCLK) begin
        if (RST) begin
            IRQ_ENABLE <= RST_IRQ_EN;
        end else if (op == OP_INT_EXIT) begin
            IRQ_ENABLE <= 1'b1;
        end
    end

    // File registers; the port write wins a same-cycle collision
    always_ff @(posedge MCLK) begin
        if (op == OP_ACC_FILE) begin
            file_mem[fidx] <= ACC;
        end else if (dest_op && to_file) begin
            file_mem[fidx] <= cif.res;
        end
        if (REG_WR) begin
            file_mem[REG_ADDR] <= REG_WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= file_mem[REG_ADDR];
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // Special registers sit in peripherals; this is their write strobe
    always_ff @(posedge MCLK) begin
        if (RST) begin
            SPR_WE <= 1'b0;
            SPR_ADDR <= 6'h00;
            SPR_DATA <= 8'h00;
        end else begin
            SPR_WE <= (op == OP_ACC_SPR);
            if (op == OP_ACC_SPR) begin
                SPR_ADDR <= PROG_DATA[5:0];
                SPR_DATA <= ACC;
            end
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_refill_then_run;
        state == ST_REFILL ##1 state == ST_RUN;
    endsequence

    a_nop_advance: assert property (
        (state == ST_RUN && PROG_DATA == OPC_NOP && !REG_WR)
        |=> PROG_ADDR == PC_W'($past(PROG_ADDR) + 1'b1) && $stable(ACC)
            && $stable(ZERO) && $stable(CARRY))
        else $error("no-operation changed state");

    a_file_copy: assert property (
        (op == OP_ACC_FILE && !REG_WR)
        |=> file_mem[$past(fidx)] == $past(ACC) && $stable(ZERO)
            && $stable(CARRY))
        else $error("file move wrong");

    a_spr_strobe: assert property (
        op == OP_ACC_SPR |=> SPR_WE && SPR_DATA == $past(ACC)
            && SPR_ADDR == $past(PROG_DATA[5:0])
        ##1 SPR_WE == $past(op == OP_ACC_SPR))
        else $error("special move strobe wrong");

    a_int_exit: assert property (
        op == OP_INT_EXIT |=> IRQ_ENABLE && PROG_ADDR == $past(cif.top)
            ##0 s_refill_then_run)
        else $error("interrupt exit wrong");

    a_table_exit: assert property (
        op == OP_TABLE_EXIT |=> ACC == $past(lit)
            && PROG_ADDR == $past(cif.top))
        else $error("table exit wrong");

    a_sub_exit: assert property (
        op == OP_SUB_EXIT |=> PROG_ADDR == $past(cif.top) && $stable(ZERO)
            && $stable(CARRY) ##0 s_refill_then_run)
        else $error("subroutine exit wrong");

    a_rotate_carry: assert property (
        op == OP_ROT_LEFT |=> CARRY == $past(fv[7]))
        else $error("rotate left carry wrong");

    a_rotate_right: assert property (
        (op == OP_ROT_RIGHT && !to_file)
        |=> CARRY == $past(fv[0]) && ACC == {$past(CARRY), $past(fv[7:1])})
        else $error("rotate right wrong");

    a_standby_flags: assert property (
        op == OP_STANDBY |=> HALTED && TIMEOUT && !POWERDOWN
            && $stable(PROG_ADDR))
        else $error("standby entry wrong");

    a_sub_borrow: assert property (
        op == OP_FILE_MINUS_ACC
        |=> CARRY == ($past(fv) >= $past(ACC))
            && ZERO == ($past(fv) == $past(ACC)))
        else $error("subtract flags wrong");

    a_zero_test: assert property (
        (op == OP_ZERO_TEST && !REG_WR)
        |=> ZERO == ($past(fv) == 8'h00) && $stable(ACC))
        else $error("zero test wrong");

    a_xor_literal: assert property (
        op == OP_XOR_LIT |=> ACC == ($past(ACC) ^ $past(lit))
            && ZERO == (ACC == 8'h00))
        else $error("literal xor wrong");

    a_rotate_left: assert property (
        (op == OP_ROT_LEFT && !to_file)
        |=> ACC == {$past(fv[6:0]), $past(CARRY)} && $stable(ZERO))
        else $error("rotate left result wrong");

    a_sub_result: assert property (
        (op == OP_FILE_MINUS_ACC && !to_file)
        |=> ACC == 8'($past(fv) - $past(ACC)))
        else $error("subtract result wrong");

    a_sub_half: assert property (
        op == OP_FILE_MINUS_ACC
        |=> HALF_CARRY == ($past(fv[3:0]) >= $past(ACC[3:0])))
        else $error("subtract half carry wrong");

    a_nibble_swap: assert property (
        (op == OP_NIBBLE && !to_file)
        |=> ACC == {$past(fv[3:0]), $past(fv[7:4])} && $stable(CARRY)
            && $stable(ZERO) && $stable(HALF_CARRY))
        else $error("nibble exchange wrong");

    a_xor_file: assert property (
        (op == OP_XOR_FILE && to_file && !REG_WR)
        |=> file_mem[$past(fidx)] == ($past(fv) ^ $past(ACC))
            && $stable(ACC))
        else $error("file xor wrong");

    a_zero_clear: assert property (
        (op == OP_ZERO_TEST && fv != 8'h00) |=> !ZERO)
        else $error("zero test left zero set");

    a_call_push: assert property (
        op == OP_CALL |=> PROG_ADDR == $past(PROG_DATA[9:0])
            && cif.top == PC_W'($past(ex_pc) + 1'b1))
        else $error("call push wrong");

endmodule : mcd_core

//--- mcd_pkg.sv
package mcd_pkg;

    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int FILE_AW = 7;
    localparam int SPR_AW = 6;
    localparam int FILE_DEPTH = 128;

    localparam logic [SPR_AW-1:0] SPR_LAST = 6'h12;

    // Whole-word opcodes
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [13:0] OPC_STANDBY = 14'h0003;
    localparam logic [13:0] OPC_SUB_EXIT = 14'h0040;
    localparam logic [13:0] OPC_INT_EXIT = 14'h0060;

    // Opcode groups: bits 13:7, bits 13:8 and bits 13:10
    localparam logic [6:0] OPG_ACC_FILE = 7'h01;
    localparam logic [6:0] OPG_ZERO_TEST = 7'h11;
    localparam logic [5:0] OPG_FILE_MINUS_ACC = 6'h02;
    localparam logic [5:0] OPG_XOR_ACC_FILE = 6'h06;
    localparam logic [5:0] OPG_ROT_RIGHT = 6'h0C;
    localparam logic [5:0] OPG_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OPG_NIBBLE = 6'h0E;
    localparam logic [5:0] OPG_TABLE_EXIT = 6'h18;
    localparam logic [5:0] OPG_XOR_LIT = 6'h1F;
    localparam logic [3:0] OPG_CALL = 4'h8;

    // Values after reset
    localparam logic [PC_W-1:0] RST_PC = 10'h000;
    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic RST_TIMEOUT = 1'b1;
    localparam logic RST_POWERDOWN = 1'b1;
    localparam logic RST_IRQ_EN = 1'b0;

    typedef enum logic [3:0] {
        OP_NOP, OP_ACC_FILE, OP_ACC_SPR, OP_INT_EXIT, OP_SUB_EXIT,
        OP_TABLE_EXIT, OP_ROT_LEFT, OP_ROT_RIGHT, OP_FILE_MINUS_ACC,
        OP_NIBBLE, OP_ZERO_TEST, OP_XOR_LIT, OP_XOR_FILE, OP_STANDBY,
        OP_CALL
    } mcd_op_t;

    typedef enum logic [1:0] {ST_REFILL, ST_RUN, ST_SLEEP} mcd_state_t;

    // Words outside this block's half of the set decode as OP_NOP
    function automatic mcd_op_t mcd_decode(input logic [13:0] w);
        mcd_op_t r;
        r = OP_NOP;
        if (w == OPC_STANDBY) begin
            r = OP_STANDBY;
        end else if (w == OPC_SUB_EXIT) begin
            r = OP_SUB_EXIT;
        end else if (w == OPC_INT_EXIT) begin
            r = OP_INT_EXIT;
        end else if (w[13:6] == 8'h00 && w != OPC_NOP
                     && w[5:0] != 6'h04 && w[5:0] <= SPR_LAST) begin
            r = OP_ACC_SPR;
        end else if (w[13:7] == OPG_ACC_FILE) begin
            r = OP_ACC_FILE;
        end else if (w[13:7] == OPG_ZERO_TEST) begin
            r = OP_ZERO_TEST;
        end else if (w[13:10] == OPG_CALL) begin
            r = OP_CALL;
        end else begin
            case (w[13:8])
                OPG_FILE_MINUS_ACC: r = OP_FILE_MINUS_ACC;
                OPG_XOR_ACC_FILE: r = OP_XOR_FILE;
                OPG_ROT_RIGHT: r = OP_ROT_RIGHT;
                OPG_ROT_LEFT: r = OP_ROT_LEFT;
                OPG_NIBBLE: r = OP_NIBBLE;
                OPG_TABLE_EXIT: r = OP_TABLE_EXIT;
                OPG_XOR_LIT: r = OP_XOR_LIT;
                default: r = OP_NOP;
            endcase
        end
        return r;
    endfunction : mcd_decode

endpackage : mcd_pkg

//--- mcd_core_if.sv
`timescale 1ns/1ns
interface mcd_core_if;
    import mcd_pkg::*;
    mcd_op_t op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] res;
    logic cin;
    logic cout;
    logic hcarry;
    logic zero;
    logic push;
    logic pop;
    logic [PC_W-1:0] din;
    logic [PC_W-1:0] top;
    modport core(output op, a, b, cin, push, pop, din,
                 input res, cout, hcarry, zero, top);
    modport alu(input op, a, b, cin, output res, cout, hcarry, zero);
    modport stk(input push, pop, din, output top);
endinterface : mcd_core_if

//--- mcd_alu.sv
`timescale 1ns/1ns
module mcd_alu import mcd_pkg::*; (
    mcd_core_if.alu bus
);
    logic [8:0] diff;
    logic [4:0] hdiff;

    always_comb begin
        // Two's complement: a + ~b + 1, carry out means no borrow
        diff = 9'({1'b0, bus.a} + {1'b0, ~bus.b} + 9'h001);
        hdiff = 5'({1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + 5'h01);
        bus.res = bus.a;
        bus.cout = bus.cin;
        bus.hcarry = 1'b0;
        case (bus.op)
            OP_FILE_MINUS_ACC: begin
                bus.res = diff[7:0];
                bus.cout = diff[8];
                bus.hcarry = hdiff[4];
            end
            OP_ROT_LEFT: begin
                bus.res = {bus.a[6:0], bus.cin};
                bus.cout = bus.a[7];
            end
            OP_ROT_RIGHT: begin
                bus.res = {bus.cin, bus.a[7:1]};
                bus.cout = bus.a[0];
            end
            OP_NIBBLE: bus.res = {bus.a[3:0], bus.a[7:4]};
            OP_XOR_LIT, OP_XOR_FILE: bus.res = bus.a ^ bus.b;
            default: bus.res = bus.a;
        endcase
        bus.zero = (bus.res == 8'h00);
    end

endmodule : mcd_alu

//--- mcd_stack.sv
`timescale 1ns/1ns
module mcd_stack import mcd_pkg::*; #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    mcd_core_if.stk bus
);
    localparam int PW = $clog2(DEPTH);

    logic [PC_W-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;

    // Circular: a push beyond depth overwrites the oldest entry
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= '0;
        end else if (bus.push) begin
            ptr <= PW'(ptr + 1'b1);
        end else if (bus.pop) begin
            ptr <= PW'(ptr - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (bus.push) begin
            mem[ptr] <= bus.din;
        end
    end

    assign bus.top = mem[PW'(ptr - 1'b1)];

endmodule : mcd_stack

//--- mcd_prog_mem.sv
`timescale 1ns/1ns
module mcd_prog_mem import mcd_pkg::*; (
    input wire logic clk,
    input wire logic [PC_W-1:0] addr,
    output logic [INSTR_W-1:0] data
);
    logic [INSTR_W-1:0] mem [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 14'h0000;
        end
    end

    // Synchronous read: the word follows its address by one cycle
    always_ff @(posedge clk) begin
        data <= mem[addr];
    end
endmodule : mcd_prog_mem

//--- test_mcd_core.sv
`timescale 1ns/1ns
module test_mcd_core;
    import mcd_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic [FILE_AW-1:0] reg_addr = 7'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data;
    logic [DATA_W-1:0] reg_rdata, acc, spr_data;
    logic carry, half_carry, zero, timeout, powerdown;
    logic irq_enable, halted, spr_we;
    logic [SPR_AW-1:0] spr_addr;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int pc = 0;
    logic [31:0] rnd = 32'h75092D3B;
    logic [13:0] op_tab [7] = '{14'h0080, 14'h0880, 14'h0200, 14'h0600,
                                14'h0C00, 14'h0D00, 14'h0E00};
    int m_acc, m_c, m_hc, m_z, m_ie, m_tmo, m_pwd, m_halt;
    int m_pa, m_prev, m_refill, m_we, m_sa, m_sd, m_rd;
    int m_file [128];
    int m_stk [$];
    bit chk_on = 1'b0;

    mcd_core #(.STACK_DEPTH(8)) u_dut (.MCLK(mclk), .RST(rst),
        .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .WAKE(wake),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACC(acc), .CARRY(carry),
        .HALF_CARRY(half_carry), .ZERO(zero), .TIMEOUT(timeout),
        .POWERDOWN(powerdown), .IRQ_ENABLE(irq_enable), .HALTED(halted),
        .SPR_WE(spr_we), .SPR_ADDR(spr_addr), .SPR_DATA(spr_data));
    mcd_prog_mem u_mem (.clk(mclk), .addr(prog_addr), .data(prog_data));

    always #50 mclk = ~mclk;

    function automatic logic [7:0] rnd8();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd[7:0];
    endfunction : rnd8

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic emit(input logic [13:0] w);
        u_mem.mem[pc] = w;
        pc++;
    endtask : emit

    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : reg_write

    task automatic reg_read(input logic [6:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask : reg_read

    // Cycle model; the fetched word lags the address by one cycle
    always @(posedge mclk) begin : model
        int w, f, v, r, ex, npa;
        m_we = 0;
        if (rst) begin
            m_acc = 0; m_c = 0; m_hc = 0; m_z = 0; m_ie = 0;
            m_tmo = 1; m_pwd = 1; m_halt = 0; m_pa = 0; m_prev = 0;
            m_refill = 1; m_stk.delete();
        end else if (!m_halt) begin
            w = u_mem.mem[m_prev];
            f = w & 'h7F;
            v = m_file[f];
            r = -1;
            ex = m_prev;
            npa = (m_pa + 1) % 1024;
            if (m_refill) begin
                m_refill = 0;
            end else if (w == 'h3) begin
                m_halt = 1; m_tmo = 1; m_pwd = 0; npa = m_pa;
            end else if (w == 'h40 || w == 'h60) begin
                npa = m_stk.pop_back(); m_refill = 1;
                if (w == 'h60) m_ie = 1;
            end else if ((w >> 6) == 0 && w != 0 && (w & 63) != 4
                         && (w & 63) <= 'h12) begin
                m_we = 1; m_sa = w & 63; m_sd = m_acc;
            end else if ((w >> 7) == 'h01) begin
                m_file[f] = m_acc;
            end else if ((w >> 7) == 'h11) begin
                m_z = (v == 0);
            end else if ((w >> 10) == 8) begin
                m_stk.push_back((ex + 1) % 1024);
                npa = w & 1023; m_refill = 1;
            end else begin
                case (w >> 8)
                    'h02: begin
                        r = (v - m_acc) & 255; m_c = (v >= m_acc);
                        m_hc = ((v & 15) >= (m_acc & 15)); m_z = (r == 0);
                    end
                    'h06: begin r = v ^ m_acc; m_z = (r == 0); end
                    'h0C: begin r = (v >> 1) | (m_c << 7); m_c = v & 1; end
                    'h0D: begin r = ((v << 1) & 255) | m_c; m_c = v >> 7; end
                    'h0E: r = ((v << 4) | (v >> 4)) & 255;
                    'h18: begin
                        m_acc = w & 255; npa = m_stk.pop_back(); m_refill = 1;
                    end
                    'h1F: begin
                        m_acc = m_acc ^ (w & 255);
                        m_z = (m_acc == 0);
                    end
                    default: ;
                endcase
            end
            if (r >= 0) begin
                if (w & 'h80) m_file[f] = r;
                else m_acc = r;
            end
            m_prev = m_pa;
            m_pa = npa;
        end
        if (!rst && reg_wr) m_file[reg_addr] = reg_wdata;
        m_rd = (!rst && reg_rd) ? m_file[reg_addr] : 0;
    end

    always @(negedge mclk) begin
        if (chk_on && !rst) begin
            check(prog_addr, m_pa);
            check(acc, m_acc);
            check(carry, m_c);
            check(half_carry, m_hc);
            check(zero, m_z);
            check(irq_enable, m_ie);
            check(halted, m_halt);
            check(timeout, m_tmo);
            check(powerdown, m_pwd);
            check(spr_we, m_we);
            if (m_we) begin
                check({spr_addr, spr_data}, (m_sa << 8) | m_sd);
            end
            check(reg_rdata, m_rd);
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin : main
        int i, t, tail, exp_acc;
        #1;
        // Leading no-op words leave room for the register port preload
        pc = 24;
        for (i = 0; i < 28; i++) begin
            emit({6'h1F, rnd8()});
            emit(op_tab[i % 7] | (((i / 7) % 2) ? 14'h0080 : 14'h0000)
                 | 14'(32 + i % 8));
        end
        emit(14'h00B0);
        emit(14'h0230);
        emit(14'h08B1);
        emit(14'h08B0);
        emit({6'h1F, 8'h00});
        emit({6'h1F, 8'hFF});
        emit({6'h1F, rnd8()});
        emit(14'h0001);
        emit(14'h0012);
        emit(14'h0013);
        emit(14'h0004);
        emit(14'h2200);
        emit(14'h2220);
        tail = pc;
        pc += 40;
        emit(14'h0003);
        emit({6'h1F, 8'h5A});
        pc = 'h200;
        emit({6'h1F, rnd8()});
        emit(14'h2210);
        emit(14'h0040);
        pc = 'h210;
        emit({6'h18, rnd8()});
        pc = 'h220;
        emit(14'h0060);
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        chk_on = 1'b1;
        for (i = 0; i < 8; i++) reg_write(7'(32 + i), rnd8());
        reg_write(7'h30, rnd8());
        reg_write(7'h31, 8'h00);
        t = 0;
        while (m_prev != tail) begin
            @(posedge mclk);
            t++;
        end
        for (i = 32; i < 40; i++) reg_read(7'(i));
        reg_read(7'h30);
        t = 0;
        while (!m_halt) begin
            @(posedge mclk);
            t++;
        end
        repeat (4) @(posedge mclk);
        exp_acc = m_acc ^ 'h5A;
        chk_on = 1'b0;
        wake <= 1'b1;
        t = 0;
        while (halted !== 1'b0 && t < 8) begin
            @(posedge mclk);
            #1;
            t++;
        end
        check(halted, 0);
        @(posedge mclk);
        wake <= 1'b0;
        repeat (8) @(posedge mclk);
        check(acc, exp_acc);
        check({timeout, powerdown}, 2'b10);
        wrap_up();
    end
endmodule : test_mcd_core
